// ### src/plmc_defs.svh
// timing constants and field positions for the link mode and power control block
// assumes a 20 MHz clk_in; the reset and link-drop counts derive from the clock rate below
`ifndef PLMC_DEFS_SVH
`define PLMC_DEFS_SVH
`define PLMC_CLK_HZ          20000000
`define PLMC_LINK_DROP_MS    1200
`define PLMC_LINK_DROP_CYC   (`PLMC_LINK_DROP_MS * (`PLMC_CLK_HZ / 1000))
`define PLMC_PMT_RST_MS      2
`define PLMC_PMT_RST_CYC     (`PLMC_PMT_RST_MS * (`PLMC_CLK_HZ / 1000))
`define PLMC_BCR_RST_US      256
`define PLMC_BCR_RST_CYC     (`PLMC_BCR_RST_US * (`PLMC_CLK_HZ / 1000000))
`define PLMC_XOVER_CYC       32'h0000_4000
`define PLMC_XOVER_EXT_CYC   32'h0001_0000
`define PLMC_NLP_BASE_CYC    32'h0003_0D40
`define PLMC_RXWIN_BASE_CYC  32'h0003_0D40
`define PLMC_BIT_RESET       15
`define PLMC_BIT_SPEED       13
`define PLMC_BIT_ANEG_EN     12
`define PLMC_BIT_PWRDN       11
`define PLMC_BIT_ANEG_RST    9
`define PLMC_BIT_DUPLEX      8
`define PLMC_BIT_NO_CARRIER  10
`endif

// ### src/plmc_pkg.sv
// types shared by the link mode and power control block
package plmc_pkg;
   // link sequencing states
   typedef enum logic [2:0] {
      PLMC_ST_RESET   = 3'b000,
      PLMC_ST_DROP    = 3'b001,
      PLMC_ST_NEG     = 3'b010,
      PLMC_ST_LINK    = 3'b011,
      PLMC_ST_PWRDN   = 3'b100,
      PLMC_ST_SLEEP   = 3'b101
   } plmc_state_type;
   // energy detect sleep configuration
   typedef struct packed {
      logic       enable;
      logic       tx_pulse_en;
      logic [1:0] tx_interval_sel;
      logic       rx_single_wake;
      logic [1:0] rx_interval_sel;
      logic       xover_extend;
   } plmc_sleep_cfg_type;
   // resolved operating mode
   typedef struct packed {
      logic speed_100;
      logic full_duplex;
      logic forced;
   } plmc_mode_type;
endpackage

// ### src/plmc_timer.sv
// one-shot down counter used for the long durations
// assumes start pulses come from the same clock domain
`timescale 1ns/1ps
module plmc_timer #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             start_in,
   input  wire logic [WIDTH-1:0] count_in,
   output logic                  busy_out,
   output logic                  done_out
);
   logic [WIDTH-1:0] cnt_r;

   // refuse widths too narrow for the durations
   if (WIDTH < 8) $error("plmc_timer: WIDTH too small");

   ////////////////////////////////////////////////////////////////////////
   // (R20) count down from the loaded value, pulse done at zero
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r    <= '0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else if (start_in) begin
         cnt_r    <= count_in;
         busy_out <= 1'b1;
         done_out <= 1'b0;
      end else if (busy_out && cnt_r <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
         cnt_r    <= '0;
         busy_out <= 1'b0;
         done_out <= 1'b1;
      end else begin
         cnt_r    <= busy_out ? cnt_r - {{(WIDTH-1){1'b0}}, 1'b1} : cnt_r;
         done_out <= 1'b0;
      end
   end
endmodule // plmc_timer

// ### src/plmc_top.sv
// link mode, carrier sense, crossover, power-down and soft reset control
// assumes control bits come from a management block on clk_in; line
// status inputs come from the analog front end; signal present, line energy and link pulse are synchronised here
//
// Behaviour
// (R1) control restart bit restarts negotiation anytime; ignored here in the power-down state (not energy sleep) and while negotiation is off
// (R2) link loss restarts negotiation automatically
// (R3) management restart halts traffic, waits link-drop time
// (R4) negotiation off forces speed and duplex bits
// (R5) negotiation on ignores speed and duplex bits
// (R6) half duplex: carrier follows tx and rx
// (R7) full duplex: carrier rx only, no collisions
// (R8) full duplex transmit holds carrier sense low
// (R9) carrier sense drives no-carrier status flag; here set in half duplex only, from transmit with no signal present
// (R10) auto crossover, disabled by bit or strap
// (R11) forced modes extend crossover time when configured
// (R12) power-down bit sleeps; clearing resets device
// (R13) energy sleep: powered down, no transmit
// (R14) energy wakes, restores state, sets event flag; wake always re-enters negotiation here
// (R15) host tolerates lost wake packets
// (R16) sleep link pulses only when enabled, interval-spaced
// (R17) wake on one pulse or two within window
// (R18) power control reset self-clears after 2ms
// (R19) control reset self-clears after 256us
// (R20) durations timed by reference clock counters
`timescale 1ns/1ps
`include "plmc_defs.svh"
module plmc_top #(
   parameter int LINK_DROP_CYC = `PLMC_LINK_DROP_CYC,
   parameter int PMT_RST_CYC   = `PLMC_PMT_RST_CYC,
   parameter int BCR_RST_CYC   = `PLMC_BCR_RST_CYC,
   parameter int NLP_BASE_CYC  = `PLMC_NLP_BASE_CYC,
   parameter int RXWIN_CYC     = `PLMC_RXWIN_BASE_CYC,
   parameter int XOVER_CYC     = `PLMC_XOVER_CYC,
   parameter int XOVER_EXT_CYC = `PLMC_XOVER_EXT_CYC
) (
   input  wire logic                        clk_in,
   input  wire logic                        rst_in,
   input  wire logic [15:0]                 basic_control_reg_in,
   input  wire logic                        basic_control_wr_in,
   input  wire logic                        transceiver_soft_reset_bit_in,
   input  wire logic                        crossover_disable_in,
   input  wire logic                        auto_crossover_strap_in,
   input  wire plmc_pkg::plmc_sleep_cfg_type sleep_cfg_in,
   input  wire logic                        energy_event_clear_in,
   input  wire logic                        tx_active_in,
   input  wire logic                        rx_activity_in,
   input  wire logic                        signal_present_in,
   input  wire logic                        line_energy_in,
   input  wire logic                        link_pulse_in,
   input  wire logic                        pair_match_in,
   input  wire logic                        aneg_done_in,
   input  wire logic                        aneg_speed_100_in,
   input  wire logic                        aneg_full_duplex_in,
   output plmc_pkg::plmc_mode_type          mode_out,
   output logic                             aneg_start_out,
   output logic                             traffic_halt_out,
   output logic                             carrier_sense_out,
   output logic                             collision_out,
   output logic                             no_carrier_out,
   output logic                             pairs_swapped_out,
   output logic                             powered_down_out,
   output logic                             energy_present_out,
   output logic                             energy_event_flag_out,
   output logic                             link_pulse_tx_out,
   output logic                             bcr_reset_busy_out,
   output logic                             pmt_reset_busy_out,
   output logic                             transceiver_reset_out
);

   plmc_pkg::plmc_state_type state_r;
   logic [2:0] sig_s_r, nrg_s_r, lp_s_r;
   logic       sig_q, nrg_q, lp_rise;
   logic       aneg_en, pwrdn_req;
   logic       bcr_start, pmt_start;
   logic       drop_start, drop_busy, drop_done;
   logic       rst_done_bcr, rst_done_pmt;
   logic [31:0] nlp_cnt_r, win_cnt_r, xo_cnt_r;
   logic       first_pulse_r, wake;
   logic       lp_q_r;

   // refuse timing counts that the timers cannot serve
   if (LINK_DROP_CYC < 1 || BCR_RST_CYC < 1 || PMT_RST_CYC < 1 || NLP_BASE_CYC < 1)
      $error("plmc_top: timing counts must be at least one cycle");

   // decode a speed/duplex pair from control bits or negotiation result
   function automatic plmc_pkg::plmc_mode_type pick_mode(input logic en, input logic [15:0] c,
                                                        input logic s, input logic d);
      plmc_pkg::plmc_mode_type m;
      m.forced      = ~en;
      m.speed_100   = en ? s : c[`PLMC_BIT_SPEED];
      m.full_duplex = en ? d : c[`PLMC_BIT_DUPLEX];
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // three-stage synchronisers; change counted when stages two and three agree
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sig_s_r <= 3'h0;
         nrg_s_r <= 3'h0;
         lp_s_r  <= 3'h0;
         sig_q   <= 1'b0;
         nrg_q   <= 1'b0;
      end else begin
         sig_s_r <= {sig_s_r[1:0], signal_present_in};
         nrg_s_r <= {nrg_s_r[1:0], line_energy_in};
         lp_s_r  <= {lp_s_r[1:0], link_pulse_in};
         if (sig_s_r[1] == sig_s_r[2]) sig_q <= sig_s_r[2];
         if (nrg_s_r[1] == nrg_s_r[2]) nrg_q <= nrg_s_r[2];
      end
   end
   assign lp_rise = lp_s_r[1] & lp_s_r[2] & ~lp_q_r;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) lp_q_r <= 1'b0;
      else if (lp_s_r[1] == lp_s_r[2]) lp_q_r <= lp_s_r[2];
   end

   assign aneg_en   = basic_control_reg_in[`PLMC_BIT_ANEG_EN];
   assign pwrdn_req = basic_control_reg_in[`PLMC_BIT_PWRDN];
   assign bcr_start = basic_control_wr_in & basic_control_reg_in[`PLMC_BIT_RESET];
   assign pmt_start = transceiver_soft_reset_bit_in & ~pmt_reset_busy_out;

   ////////////////////////////////////////////////////////////////////////
   // (R19) control reset timer
   plmc_timer #(.WIDTH(32)) u_bcr_tmr (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .start_in (bcr_start),
      .count_in (32'(BCR_RST_CYC)),
      .busy_out (bcr_reset_busy_out),
      .done_out (rst_done_bcr)
   );
   // (R18) power control reset timer
   plmc_timer #(.WIDTH(32)) u_pmt_tmr (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .start_in (pmt_start),
      .count_in (32'(PMT_RST_CYC)),
      .busy_out (pmt_reset_busy_out),
      .done_out (rst_done_pmt)
   );
   // (R3) link-drop timer before renegotiation
   plmc_timer #(.WIDTH(32)) u_drop_tmr (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .start_in (drop_start),
      .count_in (32'(LINK_DROP_CYC)),
      .busy_out (drop_busy),
      .done_out (drop_done)
   );

   // (R1) restart request from the control word
   assign drop_start = basic_control_wr_in & basic_control_reg_in[`PLMC_BIT_ANEG_RST]
                       & aneg_en & (state_r != plmc_pkg::PLMC_ST_PWRDN);
   assign transceiver_reset_out = bcr_reset_busy_out | pmt_reset_busy_out;

   ////////////////////////////////////////////////////////////////////////
   // link and power state machine
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= plmc_pkg::PLMC_ST_RESET;
      end else begin
         case (state_r)
            plmc_pkg::PLMC_ST_RESET: begin
               if (!transceiver_reset_out) state_r <= plmc_pkg::PLMC_ST_NEG;
            end
            plmc_pkg::PLMC_ST_DROP: begin
               if (drop_done) state_r <= plmc_pkg::PLMC_ST_NEG;
            end
            plmc_pkg::PLMC_ST_NEG: begin
               if (!aneg_en || aneg_done_in) state_r <= plmc_pkg::PLMC_ST_LINK;
            end
            plmc_pkg::PLMC_ST_LINK: begin
               // (R2) signal loss restarts negotiation
               if (aneg_en && !sig_q) state_r <= plmc_pkg::PLMC_ST_NEG;
            end
            plmc_pkg::PLMC_ST_PWRDN: begin
               // (R12) clearing power-down resets the device
               if (!pwrdn_req) state_r <= plmc_pkg::PLMC_ST_RESET;
            end
            plmc_pkg::PLMC_ST_SLEEP: begin
               // (R14) wake re-enters negotiation
               if (wake || !sleep_cfg_in.enable) state_r <= plmc_pkg::PLMC_ST_NEG;
            end
            default: state_r <= plmc_pkg::PLMC_ST_RESET;
         endcase
         // overrides in priority order
         if (pwrdn_req) state_r <= plmc_pkg::PLMC_ST_PWRDN;
         else if (transceiver_reset_out) state_r <= plmc_pkg::PLMC_ST_RESET;
         else if (drop_start) state_r <= plmc_pkg::PLMC_ST_DROP;
         // (R13) no line energy enters energy sleep
         else if (sleep_cfg_in.enable && !nrg_q && state_r != plmc_pkg::PLMC_ST_SLEEP
                  && state_r != plmc_pkg::PLMC_ST_PWRDN && state_r != plmc_pkg::PLMC_ST_RESET)
            state_r <= plmc_pkg::PLMC_ST_SLEEP;
      end
   end

   assign powered_down_out   = (state_r == plmc_pkg::PLMC_ST_PWRDN)
                             | (state_r == plmc_pkg::PLMC_ST_SLEEP);
   assign traffic_halt_out   = powered_down_out | (state_r == plmc_pkg::PLMC_ST_DROP)
                             | (state_r == plmc_pkg::PLMC_ST_RESET);
   assign aneg_start_out     = aneg_en & (state_r == plmc_pkg::PLMC_ST_NEG);
   assign energy_present_out = nrg_q;

   ////////////////////////////////////////////////////////////////////////
   // (R4) forced or negotiated mode, registered
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) mode_out <= '0;
      // (R5) speed and duplex bits ignored while negotiating
      else mode_out <= pick_mode(aneg_en, basic_control_reg_in,
                                 aneg_speed_100_in, aneg_full_duplex_in);
   end

   ////////////////////////////////////////////////////////////////////////
   // carrier sense and collision
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         carrier_sense_out <= 1'b0;
         collision_out     <= 1'b0;
         no_carrier_out    <= 1'b0;
      end else if (traffic_halt_out) begin
         carrier_sense_out <= 1'b0;
         collision_out     <= 1'b0;
         no_carrier_out    <= 1'b0;
      end else if (mode_out.full_duplex) begin
         // (R7) rx-only carrier, collisions off
         // (R8) held low while transmitting
         carrier_sense_out <= rx_activity_in & ~tx_active_in;
         collision_out     <= 1'b0;
         // (R9) flag not meaningful in full duplex
         no_carrier_out    <= 1'b0;
      end else begin
         // (R6) half duplex carrier and collision
         carrier_sense_out <= tx_active_in | rx_activity_in;
         collision_out     <= tx_active_in & rx_activity_in;
         // (R9) no-carrier flag from transmit without signal present
         no_carrier_out    <= tx_active_in & ~sig_q; // sending onto a silent line
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // (R10) crossover hunting, swap pairs on timeout without match
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         xo_cnt_r          <= 32'h0000_0000;
         pairs_swapped_out <= 1'b0;
      end else if (crossover_disable_in || !auto_crossover_strap_in) begin
         xo_cnt_r          <= 32'h0000_0000;
         pairs_swapped_out <= 1'b0;
      end else if (pair_match_in) begin
         xo_cnt_r <= 32'h0000_0000;
      // (R11) longer switching time in forced modes
      end else if (xo_cnt_r >= 32'((mode_out.forced && sleep_cfg_in.xover_extend)
                                   ? XOVER_EXT_CYC : XOVER_CYC)) begin
         xo_cnt_r          <= 32'h0000_0000;
         pairs_swapped_out <= ~pairs_swapped_out;
      end else begin
         xo_cnt_r <= xo_cnt_r + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // (R16) sleep link pulses at the selected interval
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         nlp_cnt_r         <= 32'h0000_0000;
         link_pulse_tx_out <= 1'b0;
      end else if (state_r != plmc_pkg::PLMC_ST_SLEEP || !sleep_cfg_in.tx_pulse_en) begin
         nlp_cnt_r         <= 32'h0000_0000;
         link_pulse_tx_out <= 1'b0;
      end else if (nlp_cnt_r >= 32'(NLP_BASE_CYC) * ({30'h0, sleep_cfg_in.tx_interval_sel}
                                                     + 32'h0000_0001)) begin
         nlp_cnt_r         <= 32'h0000_0000;
         link_pulse_tx_out <= 1'b1;
      end else begin
         nlp_cnt_r         <= nlp_cnt_r + 32'h0000_0001;
         link_pulse_tx_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // (R17) wake on one pulse, or two inside the window
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         first_pulse_r <= 1'b0;
         win_cnt_r     <= 32'h0000_0000;
      end else if (state_r != plmc_pkg::PLMC_ST_SLEEP) begin
         first_pulse_r <= 1'b0;
         win_cnt_r     <= 32'h0000_0000;
      end else if (lp_rise) begin
         first_pulse_r <= ~first_pulse_r;
         win_cnt_r     <= 32'h0000_0000;
      end else if (first_pulse_r) begin
         if (win_cnt_r >= 32'(RXWIN_CYC) * ({30'h0, sleep_cfg_in.rx_interval_sel}
                                            + 32'h0000_0001))
            first_pulse_r <= 1'b0;
         win_cnt_r <= win_cnt_r + 32'h0000_0001;
      end
   end
   assign wake = (lp_rise & (sleep_cfg_in.rx_single_wake | first_pulse_r))
               | (nrg_q & ~lp_q_r);

   ////////////////////////////////////////////////////////////////////////
   // (R14) sticky energy event, set wins over clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) energy_event_flag_out <= 1'b0;
      else if (state_r == plmc_pkg::PLMC_ST_SLEEP && wake) energy_event_flag_out <= 1'b1;
      else if (energy_event_clear_in) energy_event_flag_out <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   full_dup_crs_a: assert property (@(posedge clk_in) disable iff (rst_in) // (R8)
      mode_out.full_duplex && tx_active_in && !traffic_halt_out |=> !carrier_sense_out)
      else $error("carrier sense high in full duplex transmit");
   fd_no_coll_a: assert property (@(posedge clk_in) disable iff (rst_in) // (R7)
      mode_out.full_duplex |-> ##1 !collision_out)
      else $error("collision in full duplex");
   hd_crs_a: assert property (@(posedge clk_in) disable iff (rst_in) // (R6)
      !mode_out.full_duplex && tx_active_in && !traffic_halt_out |=> carrier_sense_out)
      else $error("half duplex carrier missing");
   forced_mode_a: assert property (@(posedge clk_in) disable iff (rst_in) // (R4)
      !aneg_en |=> mode_out.speed_100 == $past(basic_control_reg_in[`PLMC_BIT_SPEED]))
      else $error("forced speed not applied");
   drop_halt_a: assert property (@(posedge clk_in) disable iff (rst_in) // (R3)
      drop_start && !pwrdn_req && !transceiver_reset_out |=> traffic_halt_out)
      else $error("restart did not halt traffic");
   pwrdn_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // (R12)
      pwrdn_req |=> powered_down_out)
      else $error("power-down not entered");
   bcr_busy_a: assert property (@(posedge clk_in) disable iff (rst_in) // (R19)
      bcr_start |=> bcr_reset_busy_out)
      else $error("control reset not started");
   evt_sticky_a: assert property (@(posedge clk_in) disable iff (rst_in) // (R14)
      energy_event_flag_out && !energy_event_clear_in |=> energy_event_flag_out)
      else $error("energy flag lost");
   sleep_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in) // (R16)
      !sleep_cfg_in.tx_pulse_en |=> !link_pulse_tx_out)
      else $error("pulse sent while disabled");
endmodule // plmc_top

// ### testbench/plmc_link_partner.sv
// remote link partner model: line energy, link pulses, receive activity
// assumes the bench calls its tasks just after a falling edge of clk_in
`timescale 1ns/1ps
module plmc_link_partner (
   input  wire logic clk_in,
   output logic      signal_present_out,
   output logic      line_energy_out,
   output logic      link_pulse_out,
   output logic      rx_activity_out
);
   ////////////////////////////////////////////////////////////////////////
   // quiet line at time zero, no pulse
   initial begin
      signal_present_out = 1'b0;
      line_energy_out    = 1'b0;
      link_pulse_out     = 1'b0;
      rx_activity_out    = 1'b0;
   end
   // wake packets may be lost, so only levels are sent
   task automatic drive_line(input logic s, input logic e, input logic r);
      signal_present_out = s;
      line_energy_out    = e;
      rx_activity_out    = r;
   endtask
   // one normal link pulse, two cycles wide so the filter settles
   task automatic pulse();
      link_pulse_out = 1'b1;
      repeat (2) @(negedge clk_in);
      link_pulse_out = 1'b0;
   endtask
endmodule // plmc_link_partner

// ### testbench/test_phy_link_mode_power_control.sv
// self-checking bench for the link mode and power control block
// assumes shortened counts; inputs change at the falling edge of clk_in
`timescale 1ns/1ps
module test_phy_link_mode_power_control;
   logic                         clk_in = 1'b0;
   logic                         rst_in = 1'b1;
   logic [15:0]                  ctl    = 16'h0000;
   logic                         wr     = 1'b0;
   logic                         pmt    = 1'b0;
   logic                         xdis   = 1'b0;
   logic                         strap  = 1'b1;
   plmc_pkg::plmc_sleep_cfg_type cfg    = '0;
   logic                         evclr  = 1'b0;
   logic                         tx     = 1'b0;
   logic                         pm     = 1'b1;
   logic                         adone  = 1'b0;
   logic                         aspd   = 1'b0;
   logic                         adup   = 1'b0;
   logic                         sig, nrg, lpin, rx;
   plmc_pkg::plmc_mode_type      mode;
   logic                         start, halt, crs, col, nocar, swp, pdn, enp, evf, lptx;
   logic                         bbusy, pbusy, trst;
   int                           miscompares = 0;
   int                           checks      = 0;
   int                           n;
   ////////////////////////////////////////////////////////////////////////
   // block under test with short counts, and the far side
   plmc_top #(.LINK_DROP_CYC(100), .PMT_RST_CYC(50),
      .NLP_BASE_CYC(20), .RXWIN_CYC(40), .XOVER_CYC(16)) i_dut (
      .clk_in(clk_in), .rst_in(rst_in), .basic_control_reg_in(ctl),
      .basic_control_wr_in(wr), .transceiver_soft_reset_bit_in(pmt),
      .crossover_disable_in(xdis), .auto_crossover_strap_in(strap),
      .sleep_cfg_in(cfg), .energy_event_clear_in(evclr), .tx_active_in(tx),
      .rx_activity_in(rx), .signal_present_in(sig), .line_energy_in(nrg),
      .link_pulse_in(lpin), .pair_match_in(pm), .aneg_done_in(adone),
      .aneg_speed_100_in(aspd), .aneg_full_duplex_in(adup), .mode_out(mode),
      .aneg_start_out(start), .traffic_halt_out(halt), .carrier_sense_out(crs),
      .collision_out(col), .no_carrier_out(nocar), .pairs_swapped_out(swp),
      .powered_down_out(pdn), .energy_present_out(enp),
      .energy_event_flag_out(evf), .link_pulse_tx_out(lptx),
      .bcr_reset_busy_out(bbusy), .pmt_reset_busy_out(pbusy),
      .transceiver_reset_out(trst));
   plmc_link_partner i_partner (.clk_in(clk_in), .signal_present_out(sig),
      .line_energy_out(nrg), .link_pulse_out(lpin), .rx_activity_out(rx));
   ////////////////////////////////////////////////////////////////////////
   // 50 ns clock, reset for four cycles
   always #25 clk_in = ~clk_in;
   initial begin
      repeat (4) @(posedge clk_in);
      @(negedge clk_in) rst_in = 1'b0;
   end
   // shared helpers
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_in);
   endtask
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic write_ctl(input logic [15:0] v);
      ctl = v;
      wr  = 1'b1;
      cyc(1);
      wr  = 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // forced and negotiated modes
   task automatic t_modes();
      write_ctl(16'h2100);
      cyc(3);
      chk(3'(mode), 3'h7); // forced 100 full
      write_ctl(16'h0000);
      cyc(3);
      chk(3'(mode), 3'h1); // forced 10 half
      {adone, aspd, adup} = 3'b101;
      write_ctl(16'h3000);
      for (int i = 0; i < 200 && mode !== 3'h2; i++) cyc(1);
      chk(3'(mode), 3'h2); // speed and duplex bits ignored
   endtask
   // carrier sense and collision in both duplex modes
   task automatic t_carrier();
      write_ctl(16'h2000);
      tx = 1'b1;
      cyc(2);
      chk(3'({crs, nocar}), 3'h3); // transmit raises carrier, line silent
      i_partner.drive_line(1'b1, 1'b1, 1'b1);
      cyc(2);
      chk(3'(col), 3'h1); // receive during transmit collides
      write_ctl(16'h2100);
      cyc(2);
      chk(3'({crs, col, nocar}), 3'h0); // full duplex transmit
      tx = 1'b0;
      cyc(2);
      chk(3'(crs), 3'h1); // carrier follows receive
      i_partner.drive_line(1'b1, 1'b1, 1'b0);
      cyc(2);
      chk(3'(crs), 3'h0); // no carrier on line
   endtask
   // restart by management and by link loss
   task automatic t_restart();
      write_ctl(16'h1200);
      chk(3'({halt, start}), 3'h2); // traffic stops at once
      ctl = 16'h1000;
      cyc(90);
      chk(3'(halt), 3'h1); // held through link drop time
      for (int i = 0; i < 30 && start !== 1'b1; i++) cyc(1);
      chk(3'({halt, start}), 3'h1); // negotiation restarts
      adone = 1'b1;
      cyc(20);
      chk(3'(start), 3'h0); // link established
      i_partner.drive_line(1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 150 && start !== 1'b1; i++) cyc(1);
      chk(3'(start), 3'h1); // signal loss restarts
   endtask
   // soft resets, power-down and crossover
   task automatic t_resets();
      write_ctl(16'h9000);
      ctl = 16'h1000;
      cyc(1);
      chk(3'({bbusy, trst}), 3'h3); // reset begins
      cyc(5114);
      chk(3'(bbusy), 3'h1); // still running
      cyc(6);
      chk(3'({bbusy, trst}), 3'h0); // self-cleared
      pmt = 1'b1;
      cyc(1);
      pmt = 1'b0;
      cyc(30);
      pmt = 1'b1;
      cyc(1);
      pmt = 1'b0;
      cyc(8);
      chk(3'({pbusy, trst}), 3'h3); // running
      cyc(17);
      chk(3'(pbusy), 3'h0); // second request ignored
      write_ctl(16'h0800);
      cyc(2);
      chk(3'(pdn), 3'h1); // powered down
      write_ctl(16'h0000);
      cyc(2);
      chk(3'(pdn), 3'h0); // powered up again
      {xdis, pm} = 2'b10;
      cyc(100);
      chk(3'(swp), 3'h0); // crossover disabled
      {xdis, strap} = 2'b00;
      cyc(20);
      chk(3'(swp), 3'h0); // strap disables crossover
      strap = 1'b1;
      for (int i = 0; i < 40 && swp !== 1'b1; i++) cyc(1);
      chk(3'(swp), 3'h1); // pairs swapped
      cfg.xover_extend = 1'b1;
      cyc(40);
      chk(3'(swp), 3'h1); // forced mode waits longer
      pm = 1'b1;
   endtask
   // energy detect sleep, pulses and wake
   task automatic t_sleep();
      cfg = '{1'b1, 1'b0, 2'h1, 1'b0, 2'h0, 1'b0};
      cyc(10);
      chk(3'(pdn), 3'h1); // sleeps without energy
      n = 0;
      repeat (100) begin cyc(1); n += int'(lptx); end
      chk(3'(n), 3'h0); // nothing transmitted
      cfg.tx_pulse_en = 1'b1;
      n = 0;
      repeat (200) begin cyc(1); n += int'(lptx); end
      chk(3'(n >= 4 && n <= 6), 3'h1); // pulses every 41 cycles
      i_partner.pulse();
      cyc(60);
      chk(3'(pdn), 3'h1); // lone pulse does not wake
      i_partner.pulse();
      cyc(10);
      i_partner.pulse();
      for (int i = 0; i < 10 && pdn !== 1'b0; i++) cyc(1);
      chk(3'(pdn), 3'h0); // two pulses in window wake
      for (int i = 0; i < 200 && pdn !== 1'b1; i++) cyc(1);
      cfg.rx_single_wake = 1'b1;
      i_partner.pulse();
      for (int i = 0; i < 10 && pdn !== 1'b0; i++) cyc(1);
      chk(3'(pdn), 3'h0); // single pulse wakes
      for (int i = 0; i < 200 && pdn !== 1'b1; i++) cyc(1);
      evclr = 1'b1;
      cyc(1);
      evclr = 1'b0;
      i_partner.drive_line(1'b0, 1'b1, 1'b0);
      for (int i = 0; i < 10 && enp !== 1'b1; i++) cyc(1);
      cyc(2);
      chk(3'({enp, pdn, evf}), 3'h5); // energy wakes, flag set
      i_partner.drive_line(1'b0, 1'b0, 1'b0);
      cfg.enable = 1'b0;
      cyc(5);
      evclr = 1'b1;
      cyc(1);
      evclr = 1'b0;
      cyc(1);
      chk(3'({pdn, evf}), 3'h0); // disabled, flag cleared
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      @(negedge rst_in);
      cyc(2);
      chk(3'({trst, evf, pdn}), 3'h0); // quiet after reset
      t_modes();
      t_carrier();
      t_restart();
      t_resets();
      t_sleep();
      summarize();
   end
   initial begin
      #1000000;
      miscompares++;
      summarize();
   end
endmodule // test_phy_link_mode_power_control
